// file: rtl/decode_pkg.sv
// Operation
// - f8 clears, f5 inverts, f9 sets carry; 2 cycles
// - fc clears, fd sets direction flag; 2 cycles
// - fa clears, fb sets interrupt enable; 2 cycles
// - f0 lock prefix, 2 cycles, locks next instruction
// - word memory operands add 4 cycles
// - addressing form 11 means register operand
// - form 00 means zero displacement, no bytes
// - form 01 takes one sign-extended displacement byte
// - form 10 takes two bytes, low first
// - selectors 000-011 sum base, index, displacement
// - selectors 100, 101, 111 one register plus displacement
// - selector 110 base pointer; direct under form 00
// - displacement bytes follow the second instruction byte
// - address computation costs 4 cycles
// - prefix 001ss110 overrides segment: extra, code, stack, data
// - register code maps words or low/high bytes
// - base pointer operands default to stack segment
// - string destinations use extra segment, no override
//
// Holds the constants and types of the operand decoder.
// Assumes a single 100 MHz core clock domain.
package decode_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_CLEAR_CARRY = 8'hF8;
	localparam logic [7:0] OPC_COMPLEMENT_CARRY = 8'hF5;
	localparam logic [7:0] OPC_SET_CARRY = 8'hF9;
	localparam logic [7:0] OPC_CLEAR_DIRECTION = 8'hFC;
	localparam logic [7:0] OPC_SET_DIRECTION = 8'hFD;
	localparam logic [7:0] OPC_CLEAR_INT_ENABLE = 8'hFA;
	localparam logic [7:0] OPC_SET_INT_ENABLE = 8'hFB;
	localparam logic [7:0] OPC_HALT = 8'hF4;
	localparam logic [7:0] OPC_WAIT = 8'h9B;
	localparam logic [7:0] OPC_LOCK = 8'hF0;
	localparam logic [7:0] OPC_NO_OPERATION = 8'h90;
	localparam logic [7:0] SEG_PREFIX_MASK = 8'hE7;
	localparam logic [7:0] SEG_PREFIX_MATCH = 8'h26;
	localparam int SEG_FIELD_LSB = 3;

	// ----------------------------------------------------------------
	// operand byte fields and cycle costs
	// ----------------------------------------------------------------
	localparam logic [1:0] MOD_NO_DISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [1:0] MOD_REGISTER = 2'h3;
	localparam logic [2:0] RM_BP_DIRECT = 3'h6;
	localparam logic [7:0] CYC_CONTROL = 8'h02;
	localparam logic [7:0] CYC_NO_OPERATION = 8'h03;
	localparam logic [7:0] CYC_WAIT = 8'h06;
	localparam logic [7:0] CYC_EA = 8'h04;
	localparam logic [7:0] CYC_WORD_EXTRA = 8'h04;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_BASE_WORD = 8'h08;
	localparam logic [7:0] ADDR_BASE_POINTER = 8'h0C;
	localparam logic [7:0] ADDR_SRC_INDEX = 8'h10;
	localparam logic [7:0] ADDR_DEST_INDEX = 8'h14;
	localparam logic [7:0] ADDR_LAST_EA = 8'h18;
	localparam logic [7:0] ADDR_LAST_CYCLES = 8'h1C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_CLEAR_CARRY = 4'b0001,
		OP_COMPLEMENT_CARRY = 4'b0010,
		OP_SET_CARRY = 4'b0011,
		OP_CLEAR_DIRECTION = 4'b0100,
		OP_SET_DIRECTION = 4'b0101,
		OP_CLEAR_INT_ENABLE = 4'b0110,
		OP_SET_INT_ENABLE = 4'b0111,
		OP_HALT = 4'b1000,
		OP_WAIT = 4'b1001,
		OP_LOCK = 4'b1010,
		OP_NO_OPERATION = 4'b1011,
		OP_OPERAND = 4'b1100
	} op_e;

	typedef enum logic [1:0] {
		SEG_EXTRA = 2'b00,
		SEG_CODE = 2'b01,
		SEG_STACK = 2'b10,
		SEG_DATA = 2'b11
	} seg_e;

	typedef enum logic [3:0] {
		ACCUMULATOR_WORD = 4'b0000,
		COUNT_WORD = 4'b0001,
		DATA_WORD = 4'b0010,
		BASE_WORD = 4'b0011,
		STACK_POINTER = 4'b0100,
		BASE_POINTER = 4'b0101,
		SRC_INDEX = 4'b0110,
		DEST_INDEX = 4'b0111,
		ACCUMULATOR_LOW_BYTE = 4'b1000,
		COUNT_LOW_BYTE = 4'b1001,
		DATA_LOW_BYTE = 4'b1010,
		BASE_LOW_BYTE = 4'b1011,
		ACCUMULATOR_HIGH_BYTE = 4'b1100,
		COUNT_HIGH_BYTE = 4'b1101,
		DATA_HIGH_BYTE = 4'b1110,
		BASE_HIGH_BYTE = 4'b1111
	} gsel_e;

	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_OPERAND = 3'b001,
		ST_DISP_LOW = 3'b010,
		ST_DISP_HIGH = 3'b011,
		ST_ISSUE = 3'b100,
		ST_WAIT_TEST = 3'b101
	} state_e;

	typedef struct packed {
		op_e op;
		logic [7:0] cycles;
		logic mem_operand;
		logic wide;
		logic bus_lock;
		seg_e segment;
		gsel_e reg_operand;
		gsel_e rm_register;
		logic [15:0] displacement;
		logic [15:0] effective_address;
	} decode_s;

endpackage : decode_pkg

// file: rtl/operand_decoder.sv
// Decodes control opcodes, prefixes and the operand address byte.
// Assumes bytes arrive in order from the prefetch queue with a
// valid/ready handshake and that software loads the address bases.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module operand_decoder
(
	input wire logic aclk, // core clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] in_byte, // instruction byte
	input wire logic in_valid, // byte offered
	output logic in_ready, // byte taken when both high
	input wire logic string_dest, // operand is a string destination
	input wire logic test_n, // coprocessor test input, low = go
	output decode_pkg::decode_s dec, // decoded instruction
	output logic dec_valid, // one-cycle result strobe
	output logic bus_lock, // exclusive bus ownership
	output logic carry, // carry flag
	output logic direction, // string direction flag
	output logic int_enable, // maskable interrupt enable flag
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	import decode_pkg::*;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic gsel_e reg_select(input logic [2:0] code,
		input logic wide);
		reg_select = gsel_e'({~wide, code});
	endfunction : reg_select

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a <= ADDR_LAST_CYCLES) && (a[1:0] == 2'h0);
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		merge = r;
	endfunction : merge

	state_e state_q;
	logic [7:0] opcode_q;
	logic [7:0] operand_q;
	logic [15:0] disp_q;
	logic override_valid_q;
	seg_e override_q;
	logic lock_q;
	logic carry_q, direction_q, int_enable_q;
	decode_s dec_q;
	logic dec_valid_q;
	logic [31:0] ctrl_q;
	logic [15:0] base_word_q, base_pointer_q, src_index_q, dest_index_q;
	logic take;
	logic [1:0] mod_f;
	logic [2:0] rm_f;

	assign mod_f = operand_q[7:6];
	assign rm_f = operand_q[2:0];
	assign take = in_valid && in_ready;
	assign in_ready = ctrl_q[0] && (state_q != ST_ISSUE)
		&& (state_q != ST_WAIT_TEST);
	assign dec = dec_q;
	assign dec_valid = dec_valid_q;
	assign bus_lock = lock_q;
	assign carry = carry_q;
	assign direction = direction_q;
	assign int_enable = int_enable_q;

	// ----------------------------------------------------------------
	// address and segment of a memory operand
	// ----------------------------------------------------------------
	logic [15:0] ea_d;
	logic uses_bp;
	seg_e seg_d;
	always_comb
	begin
		uses_bp = 1'b0;
		unique case (rm_f)
			3'h0: ea_d = base_word_q + src_index_q + disp_q;
			3'h1: ea_d = base_word_q + dest_index_q + disp_q;
			3'h2:
			begin
				ea_d = base_pointer_q + src_index_q + disp_q;
				uses_bp = 1'b1;
			end
			3'h3:
			begin
				ea_d = base_pointer_q + dest_index_q + disp_q;
				uses_bp = 1'b1;
			end
			3'h4: ea_d = src_index_q + disp_q;
			3'h5: ea_d = dest_index_q + disp_q;
			3'h6:
			begin
				if (mod_f == MOD_NO_DISP)
					ea_d = disp_q;
				else
				begin
					ea_d = base_pointer_q + disp_q;
					uses_bp = 1'b1;
				end
			end
			3'h7: ea_d = base_word_q + disp_q;
		endcase
		// string destinations ignore the prefix on purpose
		if (string_dest)
			seg_d = SEG_EXTRA;
		else if (override_valid_q)
			seg_d = override_q;
		else if (uses_bp)
			seg_d = SEG_STACK;
		else
			seg_d = SEG_DATA;
	end

	// ----------------------------------------------------------------
	// byte sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_OPCODE;
			opcode_q <= 8'h00;
			operand_q <= 8'h00;
			disp_q <= 16'h0000;
		end
		else
		begin
			unique case (state_q)
				ST_OPCODE:
					if (take)
					begin
						opcode_q <= in_byte;
						disp_q <= 16'h0000;
						if (in_byte == OPC_WAIT)
							state_q <= ST_WAIT_TEST;
						else if (in_byte[7:4] != 4'hF && in_byte != OPC_NO_OPERATION
							&& (in_byte & SEG_PREFIX_MASK) != SEG_PREFIX_MATCH)
							state_q <= ST_OPERAND;
					end
				ST_OPERAND:
					if (take)
					begin
						operand_q <= in_byte;
						// displacement follows this byte, ahead of data
						if (in_byte[7:6] == MOD_DISP8 || in_byte[7:6] == MOD_DISP16
							|| (in_byte[7:6] == MOD_NO_DISP
							&& in_byte[2:0] == RM_BP_DIRECT))
							state_q <= ST_DISP_LOW;
						else
							state_q <= ST_ISSUE;
					end
				ST_DISP_LOW:
					if (take)
					begin
						if (mod_f == MOD_DISP8)
						begin
							disp_q <= {{8{in_byte[7]}}, in_byte};
							state_q <= ST_ISSUE;
						end
						else
						begin
							disp_q <= {8'h00, in_byte};
							state_q <= ST_DISP_HIGH;
						end
					end
				ST_DISP_HIGH:
					if (take)
					begin
						disp_q <= {in_byte, disp_q[7:0]};
						state_q <= ST_ISSUE;
					end
				ST_ISSUE:
					state_q <= ST_OPCODE;
				ST_WAIT_TEST:
					if (!test_n)
						state_q <= ST_OPCODE;
				default:
					state_q <= ST_OPCODE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// prefixes and flags
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			override_valid_q <= 1'b0;
			override_q <= SEG_DATA;
			lock_q <= 1'b0;
		end
		else
		begin
			// prefixes last until the following instruction is issued
			if (dec_valid_q && dec_q.op != OP_LOCK)
			begin
				override_valid_q <= 1'b0;
				lock_q <= 1'b0;
			end
			// a prefix taken in the clearing cycle must survive it
			if (take && state_q == ST_OPCODE
				&& (in_byte & SEG_PREFIX_MASK) == SEG_PREFIX_MATCH)
			begin
				override_valid_q <= 1'b1;
				override_q <= seg_e'(in_byte[SEG_FIELD_LSB +: 2]);
			end
			if (take && state_q == ST_OPCODE && in_byte == OPC_LOCK)
				lock_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			carry_q <= 1'b0;
			direction_q <= 1'b0;
			int_enable_q <= 1'b0;
		end
		else if (take && state_q == ST_OPCODE)
		begin
			if (in_byte == OPC_CLEAR_CARRY)
				carry_q <= 1'b0;
			if (in_byte == OPC_COMPLEMENT_CARRY)
				carry_q <= ~carry_q;
			if (in_byte == OPC_SET_CARRY)
				carry_q <= 1'b1;
			if (in_byte == OPC_CLEAR_DIRECTION)
				direction_q <= 1'b0;
			if (in_byte == OPC_SET_DIRECTION)
				direction_q <= 1'b1;
			if (in_byte == OPC_CLEAR_INT_ENABLE)
				int_enable_q <= 1'b0;
			if (in_byte == OPC_SET_INT_ENABLE)
				int_enable_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// result
	// ----------------------------------------------------------------
	op_e op_d;
	logic [7:0] cyc_d;
	always_comb
	begin
		op_d = OP_NONE;
		cyc_d = CYC_CONTROL;
		unique case (in_byte)
			OPC_CLEAR_CARRY: op_d = OP_CLEAR_CARRY;
			OPC_COMPLEMENT_CARRY: op_d = OP_COMPLEMENT_CARRY;
			OPC_SET_CARRY: op_d = OP_SET_CARRY;
			OPC_CLEAR_DIRECTION: op_d = OP_CLEAR_DIRECTION;
			OPC_SET_DIRECTION: op_d = OP_SET_DIRECTION;
			OPC_CLEAR_INT_ENABLE: op_d = OP_CLEAR_INT_ENABLE;
			OPC_SET_INT_ENABLE: op_d = OP_SET_INT_ENABLE;
			OPC_HALT: op_d = OP_HALT;
			OPC_LOCK: op_d = OP_LOCK;
			OPC_NO_OPERATION:
			begin
				op_d = OP_NO_OPERATION;
				cyc_d = CYC_NO_OPERATION;
			end
			default: op_d = OP_NONE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dec_q <= '0;
			dec_valid_q <= 1'b0;
		end
		else
		begin
			dec_valid_q <= 1'b0;
			if (take && state_q == ST_OPCODE && op_d != OP_NONE)
			begin
				dec_q <= '0;
				dec_q.op <= op_d;
				dec_q.cycles <= cyc_d;
				dec_q.bus_lock <= lock_q || op_d == OP_LOCK;
				dec_valid_q <= 1'b1;
			end
			else if (state_q == ST_WAIT_TEST && !test_n)
			begin
				dec_q <= '0;
				dec_q.op <= OP_WAIT;
				dec_q.cycles <= CYC_WAIT;
				dec_q.bus_lock <= lock_q;
				dec_valid_q <= 1'b1;
			end
			else if (state_q == ST_ISSUE)
			begin
				dec_q.op <= OP_OPERAND;
				dec_q.wide <= opcode_q[0];
				dec_q.bus_lock <= lock_q;
				dec_q.reg_operand <= reg_select(operand_q[5:3], opcode_q[0]);
				dec_q.rm_register <= reg_select(rm_f, opcode_q[0]);
				dec_q.displacement <= disp_q;
				dec_q.mem_operand <= (mod_f != MOD_REGISTER);
				dec_q.effective_address <= ea_d;
				dec_q.segment <= seg_d;
				if (mod_f == MOD_REGISTER)
					dec_q.cycles <= CYC_CONTROL;
				else if (opcode_q[0])
					dec_q.cycles <= CYC_EA + CYC_WORD_EXTRA;
				else
					dec_q.cycles <= CYC_EA;
				dec_valid_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic do_write;

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= CTRL_RESET;
			base_word_q <= 16'h0000;
			base_pointer_q <= 16'h0000;
			src_index_q <= 16'h0000;
			dest_index_q <= 16'h0000;
		end
		else if (do_write)
		begin
			unique case (awaddr_q)
				ADDR_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h1;
				ADDR_BASE_WORD:
					base_word_q <= 16'(merge({16'h0, base_word_q}, wdata_q,
						wstrb_q));
				ADDR_BASE_POINTER:
					base_pointer_q <= 16'(merge({16'h0, base_pointer_q},
						wdata_q, wstrb_q));
				ADDR_SRC_INDEX:
					src_index_q <= 16'(merge({16'h0, src_index_q}, wdata_q,
						wstrb_q));
				ADDR_DEST_INDEX:
					dest_index_q <= 16'(merge({16'h0, dest_index_q}, wdata_q,
						wstrb_q));
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				ADDR_CTRL: rdata_q <= ctrl_q;
				ADDR_STATUS: rdata_q <= {26'h0, state_q == ST_WAIT_TEST,
					override_valid_q, lock_q, int_enable_q, direction_q,
					carry_q};
				ADDR_BASE_WORD: rdata_q <= {16'h0, base_word_q};
				ADDR_BASE_POINTER: rdata_q <= {16'h0, base_pointer_q};
				ADDR_SRC_INDEX: rdata_q <= {16'h0, src_index_q};
				ADDR_DEST_INDEX: rdata_q <= {16'h0, dest_index_q};
				ADDR_LAST_EA: rdata_q <= {16'h0, dec_q.effective_address};
				ADDR_LAST_CYCLES: rdata_q <= {24'h0, dec_q.cycles};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_carry_invert: assert property (@(posedge aclk) disable iff (!aresetn)
		take && state_q == ST_OPCODE && in_byte == OPC_COMPLEMENT_CARRY
		|=> carry_q != $past(carry_q) && dec_valid && dec.cycles == CYC_CONTROL)
		else $error("carry not inverted");
	a_direction_set: assert property (@(posedge aclk) disable iff (!aresetn)
		take && state_q == ST_OPCODE && in_byte == OPC_SET_DIRECTION
		|=> direction_q && dec.op == OP_SET_DIRECTION)
		else $error("direction not set");
	a_int_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		take && state_q == ST_OPCODE && in_byte == OPC_CLEAR_INT_ENABLE
		|=> !int_enable_q && dec.cycles == CYC_CONTROL)
		else $error("interrupt enable not cleared");
	a_lock_prefix: assert property (@(posedge aclk) disable iff (!aresetn)
		take && state_q == ST_OPCODE && in_byte == OPC_LOCK
		|=> bus_lock && dec_valid && dec.cycles == CYC_CONTROL)
		else $error("lock prefix not applied");
	a_word_cost: assert property (@(posedge aclk) disable iff (!aresetn)
		dec_valid && dec.op == OP_OPERAND && dec.mem_operand
		|-> dec.cycles == (dec.wide ? CYC_EA + CYC_WORD_EXTRA : CYC_EA))
		else $error("memory operand cost wrong");
	a_reg_form: assert property (@(posedge aclk) disable iff (!aresetn)
		take && state_q == ST_OPERAND && in_byte[7:6] == MOD_REGISTER
		|=> ##1 dec_valid && !dec.mem_operand)
		else $error("register form taken as memory");
	a_disp_sign: assert property (@(posedge aclk) disable iff (!aresetn)
		take && state_q == ST_DISP_LOW && mod_f == MOD_DISP8
		|=> ##1 dec_valid && dec.displacement == {{8{$past(in_byte[7], 2)}},
		$past(in_byte, 2)})
		else $error("short displacement not sign extended");
	a_string_extra: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_ISSUE && string_dest && mod_f != MOD_REGISTER
		|=> dec.segment == SEG_EXTRA)
		else $error("string destination segment wrong");
	a_wait_stall: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_WAIT_TEST && test_n |=> state_q == ST_WAIT_TEST
		&& !dec_valid)
		else $error("wait released while test high");

endmodule : operand_decoder

// file: tb/byte_feeder.sv
// Model of the prefetch queue that hands instruction bytes over.
// Assumes one clock; send is called right after a rising edge.
`timescale 1ns/1ps
module byte_feeder
(
	input wire logic aclk, // core clock
	input wire logic in_ready, // decoder takes the byte
	output logic [7:0] in_byte, // instruction byte
	output logic in_valid, // byte offered
	output logic stuck // a byte was never taken
);
	logic rdy_s;
	initial
	begin
		in_byte = 8'h00;
		in_valid = 1'b0;
		stuck = 1'b0;
	end
	always @(negedge aclk) rdy_s = in_ready;
	// valid stays up across a group so no gap hides an ordering slip
	task automatic send(input logic [7:0] q[$]);
		int n;
		foreach (q[i])
		begin
			in_byte <= q[i];
			in_valid <= 1'b1;
			n = 0;
			do @(posedge aclk); while (rdy_s !== 1'b1 && ++n < 50);
			if (n >= 50) stuck <= 1'b1;
		end
		in_valid <= 1'b0;
		// a released line must not look like a fresh byte
		in_byte <= ~q[q.size()-1];
	endtask : send
endmodule : byte_feeder

// file: tb/control_op_and_operand_address_decode_tb_top.sv
// Bench for the operand decoder: flags, lock, address forms, registers.
// Assumes byte_feeder as the queue; this module is the bus master.
`timescale 1ns/1ps
module control_op_and_operand_address_decode_tb_top;
	import decode_pkg::*;
	logic aclk, aresetn, in_valid, in_ready, string_dest, test_n, stuck;
	logic [7:0] in_byte, s_axi_awaddr, s_axi_araddr;
	decode_s dec, dec_s;
	logic dec_valid, bus_lock, carry, direction, int_enable;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, aw_s, w_s, b_s, ar_s, r_s, dv_s;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_s;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, br_s, rr_s;
	int mismatches, comparisons;
	operand_decoder dut (.*);
	byte_feeder feed (.aclk(aclk), .in_ready(in_ready),
		.in_byte(in_byte), .in_valid(in_valid), .stuck(stuck));
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// sample mid-cycle so handshakes never race the clock edge
	always @(negedge aclk)
	begin
		aw_s = s_axi_awvalid && s_axi_awready;
		w_s = s_axi_wvalid && s_axi_wready;
		ar_s = s_axi_arvalid && s_axi_arready;
		b_s = s_axi_bvalid;
		br_s = s_axi_bresp;
		r_s = s_axi_rvalid;
		rr_s = s_axi_rresp;
		rd_s = s_axi_rdata;
		dv_s = dec_valid;
		if (dec_valid === 1'b1) dec_s = dec;
	end
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic hang;
		mismatches++;
		$display("wrong value at %0t: wait ran out", $time);
		close_out();
	endtask : hang
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (aw_s === 1'b1) s_axi_awvalid <= 1'b0;
			if (w_s === 1'b1) s_axi_wvalid <= 1'b0;
		end
		while (b_s !== 1'b1 && ++n < 50);
		// bready is set high on every call and never lowered, so back-to-back writes keep it up
		if (n >= 50) hang();
		chk(32'(br_s), 32'(e));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (ar_s === 1'b1) s_axi_arvalid <= 1'b0;
		end
		while (r_s !== 1'b1 && ++n < 50);
		if (n >= 50) hang();
		chk(rd_s, e);
		chk(32'(rr_s), 32'(er));
	endtask : rd
	task automatic dwait;
		int n;
		n = 0;
		do @(posedge aclk); while (dv_s !== 1'b1 && ++n < 20);
		if (n >= 20) hang();
	endtask : dwait
	task automatic opnd(input logic [7:0] q[$], input logic [15:0] ea,
		input seg_e sg, input logic [7:0] cy, input gsel_e rg);
		feed.send(q);
		dwait();
		chk(32'(dec_s.effective_address), 32'(ea));
		chk(32'(dec_s.segment), 32'(sg));
		chk(32'(dec_s.cycles), 32'(cy));
		chk(32'(dec_s.reg_operand), 32'(rg));
	endtask : opnd
	task automatic t_regs;
		chk(32'({carry, direction, int_enable, bus_lock, dec_valid}), 0);
		rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
		wr(ADDR_BASE_WORD, 32'h1000, RESP_OKAY);
		wr(ADDR_BASE_POINTER, 32'h2000, RESP_OKAY);
		wr(ADDR_SRC_INDEX, 32'h0030, RESP_OKAY);
		wr(ADDR_DEST_INDEX, 32'h0400, RESP_OKAY);
		wr(8'h40, 32'hFFFF, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		rd(ADDR_BASE_POINTER, 32'h2000, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		@(negedge aclk) chk(32'(in_ready), 0);
		@(posedge aclk) wr(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
	endtask : t_regs
	task automatic t_flags;
		logic [7:0] o[8] = '{8'hF9, 8'hF5, 8'hF5, 8'hF8,
			8'hFD, 8'hFC, 8'hFB, 8'hFA};
		op_e p[8] = '{OP_SET_CARRY, OP_COMPLEMENT_CARRY,
			OP_COMPLEMENT_CARRY, OP_CLEAR_CARRY, OP_SET_DIRECTION,
			OP_CLEAR_DIRECTION, OP_SET_INT_ENABLE, OP_CLEAR_INT_ENABLE};
		logic [2:0] f[8] = '{3'h4, 3'h0, 3'h4, 3'h0,
			3'h2, 3'h0, 3'h1, 3'h0};
		foreach (o[i])
		begin
			feed.send('{o[i]});
			dwait();
			chk(32'(dec_s.op), 32'(p[i]));
			chk(32'(dec_s.cycles), 32'h2);
			chk(32'({carry, direction, int_enable}), 32'(f[i]));
		end
	endtask : t_flags
	task automatic t_lock;
		feed.send('{OPC_LOCK});
		dwait();
		chk(32'(dec_s.op), 32'(OP_LOCK));
		chk(32'({bus_lock, dec_s.cycles}), 32'h102);
		opnd('{8'h26, 8'h8B, 8'h07}, 16'h1000, SEG_EXTRA, 8'h08,
			ACCUMULATOR_WORD);
		chk(32'(dec_s.bus_lock), 1);
		@(negedge aclk) chk(32'(bus_lock), 0);
		@(posedge aclk);
	endtask : t_lock
	task automatic t_modes;
		opnd('{8'h8B, 8'h46, 8'hFE}, 16'h1FFE, SEG_STACK, 8'h08,
			ACCUMULATOR_WORD);
		opnd('{8'h8A, 8'h98, 8'h34, 8'h12}, 16'h2264, SEG_DATA, 8'h04,
			BASE_LOW_BYTE);
		opnd('{8'h8B, 8'h49, 8'h05}, 16'h1405, SEG_DATA, 8'h08,
			COUNT_WORD);
		opnd('{8'h8B, 8'h13}, 16'h2400, SEG_STACK, 8'h08,
			DATA_WORD);
		opnd('{8'h8B, 8'h24}, 16'h0030, SEG_DATA, 8'h08,
			STACK_POINTER);
		opnd('{8'h36, 8'h8A, 8'h36, 8'h78, 8'h56}, 16'h5678, SEG_STACK,
			8'h04, DATA_HIGH_BYTE);
		opnd('{8'h2E, 8'h8B, 8'h2F}, 16'h1000, SEG_CODE, 8'h08,
			BASE_POINTER);
		opnd('{8'h3E, 8'h8B, 8'h46, 8'h02}, 16'h2002, SEG_DATA, 8'h08,
			ACCUMULATOR_WORD);
		string_dest <= 1'b1;
		opnd('{8'h2E, 8'h8B, 8'h3D}, 16'h0400, SEG_EXTRA, 8'h08,
			DEST_INDEX);
		string_dest <= 1'b0;
		rd(ADDR_LAST_EA, 32'h0400, RESP_OKAY);
		feed.send('{8'h8A, 8'hE5});
		dwait();
		chk(32'(dec_s.mem_operand), 0);
		chk(32'(dec_s.rm_register), 32'(COUNT_HIGH_BYTE));
		chk(32'(dec_s.reg_operand), 32'(ACCUMULATOR_HIGH_BYTE));
		rd(ADDR_LAST_CYCLES, 32'h2, RESP_OKAY);
	endtask : t_modes
	task automatic t_wait;
		logic [7:0] o[3] = '{OPC_WAIT, OPC_NO_OPERATION, OPC_HALT};
		op_e p[3] = '{OP_WAIT, OP_NO_OPERATION, OP_HALT};
		logic [7:0] c[3] = '{8'h06, 8'h03, 8'h02};
		test_n <= 1'b1;
		foreach (o[i])
		begin
			feed.send('{o[i]});
			if (i == 0)
			begin
				rd(ADDR_STATUS, 32'h20, RESP_OKAY);
				chk(32'(dv_s), 0);
				test_n <= 1'b0;
			end
			dwait();
			chk(32'(dec_s.op), 32'(p[i]));
			chk(32'(dec_s.cycles), 32'(c[i]));
		end
	endtask : t_wait
	initial
	begin
		aresetn = 1'b0;
		string_dest = 1'b0;
		test_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		mismatches = 0;
		comparisons = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_flags();
		t_lock();
		t_modes();
		t_wait();
		chk(32'(stuck), 0);
		close_out();
	end
endmodule : control_op_and_operand_address_decode_tb_top
